// File: hdl/ppi_cfg.svh
// Constants for the paged identification and power-class register bank.
// Assumes inclusion by bare name from design files; definitions only.
`ifndef PPI_CFG_SVH
`define PPI_CFG_SVH
// Byte addresses on the AXI4-Lite slave (index times four)
`define PPI_ADDR_W 8
`define PPI_IDX_PAGE_SEL 4'h7
`define PPI_IDX_PWR_CLASS 4'h4
`define PPI_IDX_COMPLIANCE 4'h8
`define PPI_IDX_RSVD9 4'h9
`define PPI_IDX_OUI_HI 4'hA
`define PPI_IDX_OUI_MID 4'hB
`define PPI_IDX_OUI_LO 4'hC
`define PPI_IDX_PART_HI 4'hD
`define PPI_IDX_PART_MID 4'hE
`define PPI_IDX_PART_LO 4'hF
`define PPI_IDX_SOFT_RST 4'hE
// Page selector values and field layout of base register 7
`define PPI_PAGE_ID 3'h1
`define PPI_PAGE_VENDOR 3'h7
`define PPI_PAGE_LSB 5
`define PPI_PAGE_MSB 7
// Power class field of register 4, low three bits
`define PPI_PWR_LSB 0
`define PPI_PWR_MSB 2
// Soft hard-reset bit: bit 0 in the printed numbering is the MSB
`define PPI_SOFT_RST_BIT 7
// Compliance level reported on the identification page
`define PPI_COMPLIANCE_VAL 8'h02
// Identity codes: arbitrary neutral values
`define PPI_OUI_DEFAULT 24'h12_3456
`define PPI_PART_DEFAULT 24'hA5_5A01
// Hold count of the internal reset pulse; the pulse lasts this many clock cycles plus one
`define PPI_RST_PULSE_CYC 4'h4
`define PPI_RST_CNT_W 4
// Response codes
`define PPI_RESP_OKAY 2'h0
`define PPI_RESP_SLVERR 2'h2
`endif

// File: hdl/ppi_pkg.sv
// Types for the paged identification register bank.
// Assumes nothing beyond the configuration header.
package ppi_pkg;
   typedef logic [7:0] ppi_byte_t;
   typedef logic [2:0] ppi_pwr_t;
   typedef enum logic [2:0] {
      PPI_RST_IDLE = 3'b001,
      PPI_RST_HOLD = 3'b010,
      PPI_RST_DONE = 3'b100
   } ppi_rst_e;
endpackage

// File: hdl/ppi_soft_reset.sv
// Soft hard-reset pulse generator.
// Assumes a request pulse in the sys_clk domain; drives a reset held for a fixed count.
`timescale 1ns/1ps
`default_nettype none
`include "ppi_cfg.svh"
module ppi_soft_reset
(
   input wire logic sys_clk,
   input wire logic arst_n,
   input wire logic req,
   output logic soft_rst
);
   ppi_pkg::ppi_rst_e state;
   ppi_pkg::ppi_rst_e next_state;
   logic [`PPI_RST_CNT_W-1:0] cnt;
   wire cnt_done = (cnt == `PPI_RST_PULSE_CYC);

   always_comb
   begin
      next_state = state;
      case (state)
         ppi_pkg::PPI_RST_IDLE: if (req) next_state = ppi_pkg::PPI_RST_HOLD;
         ppi_pkg::PPI_RST_HOLD: if (cnt_done) next_state = ppi_pkg::PPI_RST_DONE;
         ppi_pkg::PPI_RST_DONE: next_state = ppi_pkg::PPI_RST_IDLE;
         default: next_state = ppi_pkg::PPI_RST_IDLE;
      endcase
   end

   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         state <= ppi_pkg::PPI_RST_IDLE;
         cnt <= '0;
         soft_rst <= 1'b0;
      end
      else
      begin
         state <= next_state;
         cnt <= (state == ppi_pkg::PPI_RST_HOLD) ? cnt + 1'b1 : '0;
         soft_rst <= (next_state == ppi_pkg::PPI_RST_HOLD);
      end
   end
endmodule
`default_nettype wire

// File: hdl/ppi_regs.sv
// Paged identification, vendor control and power-class register bank.
// Assumes an AXI4-Lite master on sys_clk and strap pins synchronous to it.
// How it works
// [R1] Writing 1 to the page selector of base register 7 shows the identification page.
// [R2] The identification page returns compliance level 02h at address 1000.
// [R3] A read-only 24-bit maker identifier sits at 1010 to 1100, MSB first.
// [R4] A read-only 24-bit part identifier sits at 1101 to 1111, MSB first.
// [R5] Writing 7 to the page selector of base register 7 shows the vendor page.
// [R6] Writing 1 to the soft hard-reset bit at vendor address 1110 resets the whole device.
// [R7] The soft hard-reset bit always reads back as zero.
// [R8] The three power-class straps give the default power field of the self-ID packet.
// [R9] The strap value is loaded after each hardware reset and software writes replace it.
// [R10] Codes 000 to 011 mean no power, or self-powered giving 15, 30 or 45 W.
// [R11] Codes 100, 110, 111 mean bus-powered using 3 W needing 0, 3 or 7 W more.
// [R12] Code 101 is held back and should not be written or strapped.
// [R13] Reserved and test locations read zero and ignore writes.
`timescale 1ns/1ps
`default_nettype none
`include "ppi_cfg.svh"
module ppi_regs
(
   input wire logic sys_clk,
   input wire logic arst_n,
   input wire logic power_class_strap_0,
   input wire logic power_class_strap_1,
   input wire logic power_class_strap_2,
   input wire logic [`PPI_ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [`PPI_ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic [2:0] self_id_pwr,
   output logic phy_reset_n
);
   // Combined reset: pin or soft request, both asynchronous to the register state
   logic soft_rst;
   logic soft_req;
   logic rst_n;
   assign rst_n = arst_n & ~soft_rst;

   ppi_soft_reset u_soft_reset
   (
      .sys_clk(sys_clk),
      .arst_n(arst_n),
      .req(soft_req),
      .soft_rst(soft_rst)
   );

   // Write channel capture
   logic aw_held;
   logic w_held;
   logic [`PPI_ADDR_W-1:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   ppi_pkg::ppi_byte_t page_reg;
   ppi_pkg::ppi_pwr_t pwr_class;
   logic strap_loaded;

   wire aw_fire = s_axi_awvalid & s_axi_awready;
   wire w_fire = s_axi_wvalid & s_axi_wready;
   wire do_write = aw_held & w_held & ~s_axi_bvalid;
   wire [3:0] w_idx = aw_addr[5:2];
   wire w_in_range = (aw_addr[`PPI_ADDR_W-1:6] == '0) & (aw_addr[1:0] == 2'h0);
   wire w_lane0 = w_strb[0];
   wire [2:0] cur_page = page_reg[`PPI_PAGE_MSB:`PPI_PAGE_LSB];
   wire on_id_page = (cur_page == `PPI_PAGE_ID);
   wire on_vendor_page = (cur_page == `PPI_PAGE_VENDOR);
   wire wr_page = do_write & w_in_range & w_lane0 & (w_idx == `PPI_IDX_PAGE_SEL);
   wire wr_pwr = do_write & w_in_range & w_lane0 & (w_idx == `PPI_IDX_PWR_CLASS);
   assign soft_req = do_write & w_in_range & w_lane0 & on_vendor_page
      & (w_idx == `PPI_IDX_SOFT_RST) & w_data[`PPI_SOFT_RST_BIT]; // [R6] [R5]
   wire [2:0] strap_code = {power_class_strap_2, power_class_strap_1,
      power_class_strap_0}; // [R8] [R10] [R11] [R12]

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr <= '0;
         w_data <= '0;
         w_strb <= '0;
      end
      else
      begin
         if (aw_fire)
         begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end
         else if (do_write)
            aw_held <= 1'b0;
         if (w_fire)
         begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         else if (do_write)
            w_held <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `PPI_RESP_OKAY;
      end
      else
      begin
         s_axi_awready <= ~aw_held & ~aw_fire & ~s_axi_bvalid;
         s_axi_wready <= ~w_held & ~w_fire & ~s_axi_bvalid;
         if (do_write)
         begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= w_in_range ? `PPI_RESP_OKAY : `PPI_RESP_SLVERR;
         end
         else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
      end
   end

   // Page selector and power class; straps load once after each reset release
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         page_reg <= 8'h00;
         pwr_class <= 3'h0;
         strap_loaded <= 1'b0;
      end
      else
      begin
         if (wr_page)
            page_reg <= w_data[7:0]; // [R1] [R5]
         if (wr_pwr)
            pwr_class <= w_data[`PPI_PWR_MSB:`PPI_PWR_LSB]; // [R9]
         else if (!strap_loaded)
            pwr_class <= strap_code; // [R9] [R8]
         strap_loaded <= 1'b1;
      end
   end

   // Read path
   wire ar_fire = s_axi_arvalid & s_axi_arready;
   wire [3:0] r_idx = s_axi_araddr[5:2];
   wire r_in_range = (s_axi_araddr[`PPI_ADDR_W-1:6] == '0) & (s_axi_araddr[1:0] == 2'h0);
   wire [23:0] oui = `PPI_OUI_DEFAULT;
   wire [23:0] part = `PPI_PART_DEFAULT;
   logic [7:0] id_byte;
   logic [7:0] rd_byte;

   always_comb
   begin
      case (r_idx)
         `PPI_IDX_COMPLIANCE: id_byte = `PPI_COMPLIANCE_VAL; // [R2]
         `PPI_IDX_OUI_HI: id_byte = oui[23:16]; // [R3]
         `PPI_IDX_OUI_MID: id_byte = oui[15:8]; // [R3]
         `PPI_IDX_OUI_LO: id_byte = oui[7:0]; // [R3]
         `PPI_IDX_PART_HI: id_byte = part[23:16]; // [R4]
         `PPI_IDX_PART_MID: id_byte = part[15:8]; // [R4]
         `PPI_IDX_PART_LO: id_byte = part[7:0]; // [R4]
         default: id_byte = 8'h00; // [R13]
      endcase
   end

   always_comb
   begin
      rd_byte = 8'h00;
      if (r_idx == `PPI_IDX_PAGE_SEL)
         rd_byte = page_reg;
      else if (r_idx == `PPI_IDX_PWR_CLASS)
         rd_byte = {5'h00, pwr_class};
      else if (on_id_page)
         rd_byte = id_byte; // [R1]
      else
         rd_byte = 8'h00; // Vendor and all other non-identification pages: soft reset bit and test bytes read zero [R7] [R13]
   end

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= `PPI_RESP_OKAY;
      end
      else
      begin
         s_axi_arready <= ~s_axi_rvalid & ~ar_fire;
         if (ar_fire)
         begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= r_in_range ? {24'h00_0000, rd_byte} : 32'h0000_0000;
            s_axi_rresp <= r_in_range ? `PPI_RESP_OKAY : `PPI_RESP_SLVERR;
         end
         else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
      end
   end

   // Outputs from flops
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         self_id_pwr <= 3'h0;
         phy_reset_n <= 1'b0;
      end
      else
      begin
         self_id_pwr <= pwr_class; // [R8]
         phy_reset_n <= 1'b1; // [R6]
      end
   end
endmodule
`default_nettype wire

// File: tb/ppi_regs_assertions.sv
// Concurrent checks on the register bank ports.
// Assumes binding to ppi_regs; the page is tracked from whole write handshakes.
`timescale 1ns/1ps
`default_nettype none
`include "ppi_cfg.svh"
module ppi_regs_checker
(
   input wire logic sys_clk,
   input wire logic arst_n,
   input wire logic power_class_strap_0,
   input wire logic power_class_strap_1,
   input wire logic power_class_strap_2,
   input wire logic [`PPI_ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [`PPI_ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic [2:0] self_id_pwr,
   input wire logic phy_reset_n
);
   logic [2:0] page;
   logic [7:0] ra;
   wire wtake = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   wire [47:0] ids = {`PPI_OUI_DEFAULT, `PPI_PART_DEFAULT};
   wire [2:0] k = 3'((ra - 8'h28) >> 2);
   wire [7:0] id_exp = ids[47 - 8 * k -: 8];
   wire id_rd = s_axi_rvalid && page == `PPI_PAGE_ID;
   // Soft reset also clears the page, like the design
   always_ff @(posedge sys_clk or negedge arst_n)
      if (!arst_n)
         page <= 3'h0;
      else if (!phy_reset_n)
         page <= 3'h0;
      else if (wtake && s_axi_awaddr == 8'h1C)
         page <= s_axi_wdata[`PPI_PAGE_MSB:`PPI_PAGE_LSB];
   always_ff @(posedge sys_clk)
      if (s_axi_arvalid && s_axi_arready)
         ra <= s_axi_araddr;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!arst_n);
   AST_COMPLIANCE: assert property (id_rd && ra == 8'h20 |-> s_axi_rdata == 32'h02)
      else $error("compliance level wrong");
   AST_RSVD_ID: assert property (id_rd && ra == 8'h24 |-> s_axi_rdata == 32'h0)
      else $error("reserved id byte not zero");
   AST_MAKER: assert property (id_rd && ra inside {8'h28, 8'h2C, 8'h30} |-> s_axi_rdata == {24'h0, id_exp})
      else $error("maker byte wrong");
   AST_PART: assert property (id_rd && ra inside {8'h34, 8'h38, 8'h3C} |-> s_axi_rdata == {24'h0, id_exp})
      else $error("part byte wrong");
   AST_VENDOR_ZERO: assert property (s_axi_rvalid && page == 3'h7 && ra[5] |-> s_axi_rdata == 32'h0)
      else $error("vendor page byte not zero");
   AST_SOFT_RESET: assert property (wtake && page == 3'h7 && s_axi_awaddr == 8'h38 && s_axi_wdata[7] |-> ##[1:3] !phy_reset_n)
      else $error("soft reset not taken");
   AST_STRAP_LOAD: assert property ($rose(phy_reset_n) |=> self_id_pwr == {power_class_strap_2, power_class_strap_1, power_class_strap_0})
      else $error("strap class not loaded");
   AST_PWR_WRITE: assert property (wtake && s_axi_awaddr == 8'h10 |-> ##3 self_id_pwr == $past(s_axi_wdata[2:0], 3))
      else $error("written class not shown");
endmodule
`default_nettype wire

// File: tb/ppi_llc_model.sv
// Link-side bus master that issues register accesses for the bench.
// Assumes the AXI4-Lite slave of ppi_regs on the same clock.
`timescale 1ns/1ps
`default_nettype none
module ppi_llc_model
(
   input wire logic sys_clk,
   output logic [7:0] s_axi_awaddr,
   output logic s_axi_awvalid,
   input wire logic s_axi_awready,
   output logic [31:0] s_axi_wdata,
   output logic [3:0] s_axi_wstrb,
   output logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   output logic s_axi_bready,
   output logic [7:0] s_axi_araddr,
   output logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   output logic s_axi_rready
);
   initial
   begin
      {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
      {s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
      s_axi_wstrb = 4'h1;
   end
   // Released payloads are inverted so nothing relies on a stale value
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic wait_b);
      logic aw;
      logic w;
      aw = 1'b1;
      w = 1'b1;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= wait_b;
      while (aw || w)
      begin
         @(posedge sys_clk);
         if (aw && s_axi_awready)
         begin
            aw = 1'b0;
            s_axi_awvalid <= 1'b0;
            s_axi_awaddr <= ~a;
         end
         if (w && s_axi_wready)
         begin
            w = 1'b0;
            s_axi_wvalid <= 1'b0;
            s_axi_wdata <= ~d;
         end
      end
      while (wait_b && !s_axi_bvalid)
         @(posedge sys_clk);
      s_axi_bready <= 1'b0;
      repeat (2) @(posedge sys_clk);
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge sys_clk); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      s_axi_araddr <= ~a;
      do @(posedge sys_clk); while (!s_axi_rvalid);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
      repeat (2) @(posedge sys_clk);
   endtask
endmodule
`default_nettype wire

// File: tb/testbench.sv
// Self-checking bench for the paged identification register bank.
// Assumes the bus master model and the bound checker.
`timescale 1ns/1ps
`default_nettype none
`include "ppi_cfg.svh"
module testbench;
   logic sys_clk = 1'b0;
   // Starts high so that the first reset gives every asynchronously reset flop a real falling edge
   logic arst_n = 1'b1;
   logic [2:0] strap = 3'h0;
   logic [31:0] d;
   logic [1:0] r;
   int fail_count = 0;
   int samples_checked = 0;
   wire logic [7:0] s_axi_awaddr, s_axi_araddr;
   wire logic [31:0] s_axi_wdata, s_axi_rdata;
   wire logic [3:0] s_axi_wstrb;
   wire logic [1:0] s_axi_bresp, s_axi_rresp;
   wire logic [2:0] self_id_pwr;
   wire logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
   wire logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, phy_reset_n;
   always #25 sys_clk = ~sys_clk;
   ppi_regs i_dut (.sys_clk, .arst_n, .power_class_strap_0(strap[0]),
      .power_class_strap_1(strap[1]), .power_class_strap_2(strap[2]), .s_axi_awaddr,
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .self_id_pwr, .phy_reset_n);
   ppi_llc_model i_llc (.sys_clk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic tally_and_finish;
      if (fail_count == 0 && samples_checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic pin_reset(input logic [2:0] s);
      strap <= s;
      arst_n <= 1'b0;
      repeat (10) @(posedge sys_clk);
      arst_n <= 1'b1;
      repeat (3) @(posedge sys_clk);
   endtask
   task automatic t_class;
      for (int c = 0; c < 16; c++)
      begin
         if (c % 8 == 5)
            continue;
         if (c < 8)
            pin_reset(3'(c));
         else
            i_llc.wr(8'h10, 32'(c - 8), 1'b1);
         i_llc.rd(8'h10, d, r);
         check("class reg", d, 32'(c % 8));
         check("class pin", 32'(self_id_pwr), 32'(c % 8));
      end
   endtask
   task automatic t_page(input logic [2:0] pg, input logic [63:0] exp);
      i_llc.wr(8'h1C, 32'(pg) << `PPI_PAGE_LSB, 1'b1);
      i_llc.wr(8'h2C, 32'hFF, 1'b1);
      i_llc.wr(8'h24, 32'hFF, 1'b1);
      for (int i = 0; i < 8; i++)
      begin
         i_llc.rd(8'(8'h20 + 4 * i), d, r);
         check("paged byte", d, 32'(exp[63 - 8 * i -: 8]));
      end
   endtask
   task automatic t_soft_reset;
      i_llc.wr(8'h10, 32'h3, 1'b1);
      i_llc.wr(8'h38, 32'h80, 1'b0);
      repeat (10) if (phy_reset_n) @(posedge sys_clk);
      check("soft reset low", 32'(phy_reset_n), 32'h0);
      repeat (20) if (!phy_reset_n) @(posedge sys_clk);
      repeat (3) @(posedge sys_clk);
      i_llc.rd(8'h10, d, r);
      check("class after soft reset", d, 32'(strap));
      i_llc.rd(8'h1C, d, r);
      check("page after soft reset", d, 32'h0);
      i_llc.rd(8'h41, d, r);
      check("unmapped data", d, 32'h0);
      check("unmapped resp", 32'(r), 32'(`PPI_RESP_SLVERR));
   endtask
   initial
   begin
      t_class;
      t_page(`PPI_PAGE_ID, {`PPI_COMPLIANCE_VAL, 8'h00, `PPI_OUI_DEFAULT, `PPI_PART_DEFAULT});
      t_page(`PPI_PAGE_VENDOR, 64'h0);
      t_soft_reset;
      tally_and_finish;
   end
   initial
   begin
      repeat (20000) @(posedge sys_clk);
      fail_count++;
      tally_and_finish;
   end
endmodule
bind ppi_regs ppi_regs_checker i_chk (.sys_clk, .arst_n, .power_class_strap_0,
   .power_class_strap_1, .power_class_strap_2, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
   .s_axi_wdata, .s_axi_wvalid, .s_axi_wready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
   .s_axi_rdata, .s_axi_rvalid, .self_id_pwr, .phy_reset_n);
`default_nettype wire
